// ==== sap_pkg.sv ====
// Shared constants for the converter control and parallel readout ends
package sap_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int RESULT_WIDTH  = 12;
	localparam int FRAC_WIDTH    = 4;
	localparam int ANALOG_WIDTH  = RESULT_WIDTH + FRAC_WIDTH;
	localparam int FULL_SCALE    = 4096;
	localparam int CONV_OVERHEAD = 2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 20;
	localparam int ACQ_MIN_NS      = 120;
	localparam int WAKE_PARTIAL_NS = 1000;
	localparam int WAKE_FULL_NS    = 500000;
	localparam int ACQ_CYCLES      =
		(ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_PARTIAL_CYCLES = WAKE_PARTIAL_NS / CLK_PERIOD_NS;
	localparam int WAKE_FULL_DEF       = WAKE_FULL_NS / CLK_PERIOD_NS;
	localparam int START_LOW_CYCLES    = 4;
	localparam int READ_CYCLES         = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
	localparam logic [RESULT_WIDTH-1:0] BUS_IDLE     = 12'hfff;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [4:0] {
		DS_ACQ   = 5'h01,
		DS_CONV  = 5'h02,
		DS_DONE  = 5'h04,
		DS_SLEEP = 5'h08,
		DS_WAKE  = 5'h10
	} sap_dev_state_t;

	typedef enum logic [6:0] {
		HS_IDLE   = 7'h01,
		HS_LOW    = 7'h02,
		HS_WAITHI = 7'h04,
		HS_WAITLO = 7'h08,
		HS_READ   = 7'h10,
		HS_PUSH   = 7'h20,
		HS_ACQ    = 7'h40
	} sap_host_state_t;

endpackage

// ==== sap_if.sv ====
// Pin bundle joining the converter end and the host end
`timescale 1ns/10ps
interface sap_if;
	import sap_pkg::*;
	logic                    convert_start_n;
	logic                    csN;
	logic                    rdN;
	logic                    sleep_depth_select;
	logic                    busy;
	logic [RESULT_WIDTH-1:0] dataOut;
	logic                    dataOeN;
	logic [RESULT_WIDTH-1:0] dataBus;

	// Undriven bus floats to a pulled-up level
	assign dataBus = dataOeN ? BUS_IDLE : dataOut;

	modport dev (
		input  convert_start_n, csN, rdN, sleep_depth_select,
		output busy, dataOut, dataOeN
	);
	modport hst (
		output convert_start_n, csN, rdN, sleep_depth_select,
		input  busy, dataBus
	);
endinterface

// ==== sap_device.sv ====
// Converter end: conversion sequencing, sleep control, parallel readout
`timescale 1ns/10ps
module sap_device
	import sap_pkg::*;
#(
	parameter int WAKE_FULL_CYCLES = WAKE_FULL_DEF
)(
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	sap_if.dev                           link,
	input  wire logic [ANALOG_WIDTH-1:0] analogIn,
	output logic                         asleep
);
	localparam int CW = $clog2(WAKE_FULL_CYCLES + 1);
	localparam logic [CW-1:0] WAKE_FULL_CNT = CW'(WAKE_FULL_CYCLES - 1);
	localparam logic [CW-1:0] WAKE_PART_CNT = CW'(WAKE_PARTIAL_CYCLES - 1);
	localparam logic [CW-1:0] OVERHEAD_CNT  = CW'(CONV_OVERHEAD);
	localparam logic [3:0]    TOP_BIT       = 4'(RESULT_WIDTH - 1);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] cvSync;
	logic [1:0] csSync;
	logic [1:0] rdSync;
	logic [1:0] psSync;
	logic       cvPrev;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cvSync <= 2'h3;
			csSync <= 2'h3;
			rdSync <= 2'h3;
			psSync <= 2'h0;
			cvPrev <= 1'b1;
		end else begin
			cvSync <= {cvSync[0], link.convert_start_n};
			csSync <= {csSync[0], link.csN};
			rdSync <= {rdSync[0], link.rdN};
			psSync <= {psSync[0], link.sleep_depth_select};
			cvPrev <= cvSync[1];
		end
	end

	logic cvFall;
	logic cvRise;
	assign cvFall = cvPrev & ~cvSync[1];
	assign cvRise = ~cvPrev & cvSync[1];

	// ****************************************
	// Conversion and sleep sequencing
	// ****************************************
	sap_dev_state_t          state;
	sap_dev_state_t          next_state;
	logic [CW-1:0]           count;
	logic [CW-1:0]           next_count;
	logic [3:0]              bitIdx;
	logic [3:0]              next_bitIdx;
	logic [ANALOG_WIDTH-1:0] sample;
	logic [ANALOG_WIDTH-1:0] next_sample;
	logic [RESULT_WIDTH-1:0] approx;
	logic [RESULT_WIDTH-1:0] next_approx;
	logic [RESULT_WIDTH-1:0] result;
	logic [RESULT_WIDTH-1:0] next_result;
	logic                    busy;
	logic                    next_busy;
	logic                    fullSleep;
	logic                    next_fullSleep;
	logic                    pending;
	logic                    next_pending;
	logic                    next_asleep;
	logic [RESULT_WIDTH-1:0] dataOut;
	logic                    dataOeN;
	logic                    next_dataOeN;
	logic                    startConv;
	logic [RESULT_WIDTH-1:0] trial;

	always_comb begin
		next_state     = state;
		next_count     = count;
		next_bitIdx    = bitIdx;
		next_sample    = sample;
		next_approx    = approx;
		next_result    = result;
		next_busy      = busy;
		next_fullSleep = fullSleep;
		next_pending   = pending;
		startConv      = 1'b0;
		trial          = approx | (RESULT_WIDTH'(1) << bitIdx);
		case (state)
			DS_ACQ: begin
				if (cvFall) begin
					startConv = 1'b1;
				end
			end
			DS_CONV: begin
				if (cvFall) begin
					startConv = 1'b1;
				end else if (count != '0) begin
					next_count = count - CW'(1);
				end else begin
					// Keep the bit if input reaches the trial level
					if (sample >= {trial, FRAC_WIDTH'(0)}) begin
						next_approx = trial;
					end
					if (bitIdx == 4'h0) begin
						next_result = (sample >= {trial, FRAC_WIDTH'(0)})
							? trial : approx;
						next_state  = DS_DONE;
					end else begin
						next_bitIdx = bitIdx - 4'h1;
					end
				end
			end
			DS_DONE: begin
				if (cvFall) begin
					startConv = 1'b1;
				end else begin
					next_busy = 1'b0;
					if (!cvSync[1]) begin
						next_state     = DS_SLEEP;
						next_fullSleep = ~psSync[1];
					end else begin
						next_state = DS_ACQ;
					end
				end
			end
			DS_SLEEP: begin
				if (cvRise) begin
					next_state   = DS_WAKE;
					next_pending = 1'b0;
					next_count   = fullSleep ? WAKE_FULL_CNT : WAKE_PART_CNT;
				end
			end
			DS_WAKE: begin
				// A start edge during wake-up is held until wake ends
				if (cvFall) begin
					next_pending = 1'b1;
				end
				if (count != '0) begin
					next_count = count - CW'(1);
				end else if (pending || cvFall) begin
					startConv = 1'b1;
				end else begin
					next_state = DS_ACQ;
				end
			end
			default: begin
				next_state = DS_ACQ;
			end
		endcase
		if (startConv) begin
			next_state   = DS_CONV;
			next_busy    = 1'b1;
			next_sample  = analogIn;
			next_approx  = '0;
			next_bitIdx  = TOP_BIT;
			next_count   = OVERHEAD_CNT;
			next_pending = 1'b0;
		end
		next_asleep  = (next_state == DS_SLEEP);
		next_dataOeN = ~(~csSync[1] & ~rdSync[1]);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state     <= DS_ACQ;
			count     <= '0;
			bitIdx    <= 4'h0;
			sample    <= '0;
			approx    <= RESULT_RESET;
			result    <= RESULT_RESET;
			busy      <= 1'b0;
			fullSleep <= 1'b0;
			pending   <= 1'b0;
			asleep    <= 1'b0;
			dataOut   <= RESULT_RESET;
			dataOeN   <= 1'b1;
		end else begin
			state     <= next_state;
			count     <= next_count;
			bitIdx    <= next_bitIdx;
			sample    <= next_sample;
			approx    <= next_approx;
			result    <= next_result;
			busy      <= next_busy;
			fullSleep <= next_fullSleep;
			pending   <= next_pending;
			asleep    <= next_asleep;
			dataOut   <= next_result;
			dataOeN   <= next_dataOeN;
		end
	end

	// ****************************************
	// Pin outputs
	// ****************************************
	assign link.busy    = busy;
	assign link.dataOut = dataOut;
	assign link.dataOeN = dataOeN;

endmodule // sap_device

// ==== sap_host.sv ====
// Host end: conversion requests, result reads and result FIFO
`timescale 1ns/10ps
module sap_fifo
	import sap_pkg::*;
#(
	parameter int WIDTH = RESULT_WIDTH,
	parameter int DEPTH = 4
)(
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    next_wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW-1:0]    next_rdPtr;
	logic [CNW-1:0]   fill;
	logic [CNW-1:0]   next_fill;
	logic             doPush;
	logic             doPop;

	always_comb begin
		doPush     = inValid && (fill != CNW'(DEPTH));
		doPop      = outReady && (fill != '0);
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		if (doPush) begin
			next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
		end
		if (doPop) begin
			next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
		end
		next_fill = fill + CNW'(doPush) - CNW'(doPop);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			fill     <= '0;
			inReady  <= 1'b0;
			outValid <= 1'b0;
		end else begin
			wrPtr    <= next_wrPtr;
			rdPtr    <= next_rdPtr;
			fill     <= next_fill;
			inReady  <= (next_fill != CNW'(DEPTH));
			outValid <= (next_fill != '0);
			if (doPush) begin
				mem[wrPtr] <= inData;
			end
		end
	end

	assign outData = mem[rdPtr];

endmodule // sap_fifo

module sap_host
	import sap_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
)(
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	sap_if.hst                           link,
	input  wire logic                    runEnable,
	input  wire logic                    sleepMode,
	input  wire logic                    sleepDepth,
	output logic                         resultValid,
	input  wire logic                    resultReady,
	output logic      [RESULT_WIDTH-1:0] resultData
);
	localparam logic [3:0] LOW_CNT  = 4'(START_LOW_CYCLES - 1);
	localparam logic [3:0] READ_CNT = 4'(READ_CYCLES - 1);
	localparam logic [3:0] ACQ_CNT  = 4'(ACQ_CYCLES - 1);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0]              busySync;
	logic [RESULT_WIDTH-1:0] dataSync0;
	logic [RESULT_WIDTH-1:0] dataSync1;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busySync  <= 2'h0;
			dataSync0 <= RESULT_RESET;
			dataSync1 <= RESULT_RESET;
		end else begin
			busySync  <= {busySync[0], link.busy};
			dataSync0 <= link.dataBus;
			dataSync1 <= dataSync0;
		end
	end

	// ****************************************
	// Request sequencing
	// ****************************************
	sap_host_state_t         state;
	sap_host_state_t         next_state;
	logic [3:0]              cnt;
	logic [3:0]              next_cnt;
	logic                    cvN;
	logic                    next_cvN;
	logic                    rdN;
	logic                    next_rdN;
	logic                    depth;
	logic                    dummy;
	logic                    next_dummy;
	logic [RESULT_WIDTH-1:0] word;
	logic [RESULT_WIDTH-1:0] next_word;
	logic                    pushValid;
	logic                    pushReady;

	always_comb begin
		next_state = state;
		next_cnt   = (cnt != 4'h0) ? cnt - 4'h1 : cnt;
		next_cvN   = cvN;
		next_rdN   = rdN;
		next_dummy = dummy;
		next_word  = word;
		pushValid  = 1'b0;
		case (state)
			HS_IDLE: begin
				if (runEnable) begin
					next_state = HS_LOW;
					next_cvN   = 1'b0;
					next_cnt   = LOW_CNT;
				end
			end
			HS_LOW: begin
				if (cnt == 4'h0) begin
					next_cvN   = ~sleepMode;
					next_state = HS_WAITHI;
				end
			end
			HS_WAITHI: begin
				if (busySync[1]) begin
					next_state = HS_WAITLO;
				end
			end
			HS_WAITLO: begin
				// Read only once busy is low again
				if (!busySync[1]) begin
					next_cvN   = 1'b1;
					next_rdN   = 1'b0;
					next_cnt   = READ_CNT;
					next_state = HS_READ;
				end
			end
			HS_READ: begin
				if (cnt == 4'h0) begin
					next_word  = dataSync1;
					next_rdN   = 1'b1;
					next_state = HS_PUSH;
				end
			end
			HS_PUSH: begin
				pushValid = ~dummy;
				if (dummy || pushReady) begin
					next_dummy = 1'b0;
					next_cnt   = ACQ_CNT;
					next_state = HS_ACQ;
				end
			end
			HS_ACQ: begin
				if (cnt == 4'h0) begin
					next_state = HS_IDLE;
				end
			end
			default: begin
				next_state = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= HS_IDLE;
			cnt   <= 4'h0;
			cvN   <= 1'b1;
			rdN   <= 1'b1;
			depth <= 1'b0;
			dummy <= 1'b1;
			word  <= RESULT_RESET;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			cvN   <= next_cvN;
			rdN   <= next_rdN;
			depth <= sleepDepth;
			dummy <= next_dummy;
			word  <= next_word;
		end
	end

	sap_fifo #(
		.WIDTH (RESULT_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) resultFifo (
		.clock    (clock),
		.rst_n    (rst_n),
		.inValid  (pushValid),
		.inReady  (pushReady),
		.inData   (word),
		.outValid (resultValid),
		.outReady (resultReady),
		.outData  (resultData)
	);

	// ****************************************
	// Pin outputs
	// ****************************************
	assign link.convert_start_n    = cvN;
	assign link.csN                = 1'b0;
	assign link.rdN                = rdN;
	assign link.sleep_depth_select = depth;

endmodule // sap_host

// ==== sap_asserts.sv ====
// Checker on the pins between converter and host
`timescale 1ns/10ps
module sap_asserts
	import sap_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire logic                    convert_start_n,
	input wire logic                    csN,
	input wire logic                    rdN,
	input wire logic                    sleep_depth_select,
	input wire logic                    busy,
	input wire logic [RESULT_WIDTH-1:0] dataOut,
	input wire logic                    dataOeN,
	input wire logic [RESULT_WIDTH-1:0] dataBus
);
	// ****
	// Pin checks
	// ****
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	start_busy_a: assert property (
		$fell(convert_start_n) && !busy |-> ##[1:120] busy)
		else $error("busy missing after start");
	busy_cause_a: assert property (
		$rose(busy) |-> $past(convert_start_n, 2) == 1'b0)
		else $error("busy rose without start");
	busy_len_a: assert property (
		$rose(busy) |-> busy[*8] ##1 busy[*7] ##1 !busy)
		else $error("busy length wrong");
	data_early_a: assert property (
		!$stable(dataOut) |-> ##1 $fell(busy))
		else $error("result not ahead of busy fall");
	bus_drive_a: assert property (
		(!csN && !rdN)[*4] |-> !dataOeN && dataBus == dataOut)
		else $error("bus not driven on read");
	bus_release_a: assert property (
		(csN || rdN)[*4] |-> dataOeN)
		else $error("bus not released");
	busy_quiet_a: assert property (
		busy |-> dataOeN && dataBus == BUS_IDLE)
		else $error("bus moved during conversion");
	acq_gap_a: assert property (
		$fell(busy) && convert_start_n |-> convert_start_n[*7])
		else $error("acquisition too short");
	select_tied_a: assert property (
		!csN)
		else $error("select not held low");
endmodule // sap_asserts

// ==== tb_top.sv ====
// Testbench joining the converter end and the host end
`timescale 1ns/10ps
module tb_top
	import sap_pkg::*;
;
	localparam int WAKE_SIM = 60;
	logic                    clock;
	logic                    rst_n;
	logic [ANALOG_WIDTH-1:0] analogIn;
	logic                    runEnable;
	logic                    sleepMode;
	logic                    sleepDepth;
	logic                    resultReady;
	logic                    resultValid;
	logic [RESULT_WIDTH-1:0] resultData;
	logic                    asleep;
	int                      error_cnt = 0;
	int                      check_count = 0;

	sap_if i_sap_if ();
	sap_device #(.WAKE_FULL_CYCLES(WAKE_SIM)) i_sap_device (
		.clock   (clock),
		.rst_n   (rst_n),
		.link    (i_sap_if),
		.analogIn(analogIn),
		.asleep  (asleep)
	);
	sap_host i_sap_host (
		.clock      (clock),
		.rst_n      (rst_n),
		.link       (i_sap_if),
		.runEnable  (runEnable),
		.sleepMode  (sleepMode),
		.sleepDepth (sleepDepth),
		.resultValid(resultValid),
		.resultReady(resultReady),
		.resultData (resultData)
	);
	sap_asserts i_sap_asserts (
		.clock             (clock),
		.rst_n             (rst_n),
		.convert_start_n   (i_sap_if.convert_start_n),
		.csN               (i_sap_if.csN),
		.rdN               (i_sap_if.rdN),
		.sleep_depth_select(i_sap_if.sleep_depth_select),
		.busy              (i_sap_if.busy),
		.dataOut           (i_sap_if.dataOut),
		.dataOeN           (i_sap_if.dataOeN),
		.dataBus           (i_sap_if.dataBus)
	);

	// ****
	// Helpers
	// ****
	task automatic check_word(input logic [RESULT_WIDTH-1:0] exp,
		input logic [RESULT_WIDTH-1:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic tick(inout int n);
		@(posedge clock);
		#1;
		n++;
	endtask

	task automatic pop(output logic [RESULT_WIDTH-1:0] w, output logic ok);
		int n;
		n = 0;
		#1;
		while (resultValid !== 1'b1 && n < 300)
			tick(n);
		ok = (resultValid === 1'b1);
		w = resultData;
		@(posedge clock);
		resultReady <= ok;
		@(posedge clock);
		resultReady <= 1'b0;
	endtask

	task automatic flush();
		logic [RESULT_WIDTH-1:0] w;
		logic ok;
		runEnable <= 1'b0;
		repeat (150) @(posedge clock);
		ok = 1'b1;
		while (ok)
			pop(w, ok);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic test_codes();
		logic [ANALOG_WIDTH-1:0] v [6] = '{16'h0000, 16'h000f,
			16'h0010, 16'h7ff8, 16'hfff0, 16'hffff};
		logic [RESULT_WIDTH-1:0] w;
		logic ok;
		foreach (v[i]) begin
			flush();
			analogIn <= v[i];
			runEnable <= 1'b1;
			pop(w, ok);
			check_flag(1'b1, ok);
			check_word(v[i][ANALOG_WIDTH-1:FRAC_WIDTH], w);
		end
	endtask

	task automatic test_fifo();
		logic [RESULT_WIDTH-1:0] w;
		logic ok;
		int n;
		flush();
		analogIn <= 16'h1230;
		runEnable <= 1'b1;
		repeat (500) @(posedge clock);
		#1;
		check_flag(1'b1, resultValid);
		@(posedge clock);
		runEnable <= 1'b0;
		n = 0;
		ok = 1'b1;
		while (ok) begin
			pop(w, ok);
			if (ok) begin
				n++;
				check_word(12'h123, w);
			end
		end
		check_word(12'h005, RESULT_WIDTH'(n));
	endtask

	task automatic test_sleep(input logic depth, input int wake);
		logic [RESULT_WIDTH-1:0] w;
		logic ok;
		int n;
		flush();
		sleepMode <= 1'b1;
		sleepDepth <= depth;
		analogIn <= 16'h0a50;
		runEnable <= 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 300)
			tick(n);
		check_flag(1'b1, asleep);
		n = 0;
		while (asleep === 1'b1 && n < 300)
			tick(n);
		n = 0;
		while (i_sap_if.busy !== 1'b1 && n < 300)
			tick(n);
		check_flag(1'b1, n >= wake);
		check_flag(1'b1, n < wake + 2);
		pop(w, ok);
		check_word(12'h0a5, w);
		sleepMode <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****
	// Run
	// ****
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		rst_n = 1'b0;
		analogIn = '0;
		runEnable = 1'b0;
		sleepMode = 1'b0;
		sleepDepth = 1'b1;
		resultReady = 1'b0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		test_codes();
		test_fifo();
		test_sleep(1'b1, WAKE_PARTIAL_CYCLES);
		test_sleep(1'b0, WAKE_SIM);
		test_done();
	end

	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
endmodule // tb_top
